// [rtl/sensor_readout_pkg.sv]
// Shared constants, upload word layout and pixel code helpers for the
// window readout pair (sensor end and timing controller end).
// Assumes both ends run from one 125 MHz clock and reset together.
package sensor_readout_pkg;

    // ****************************************************************
    // Array geometry and word widths
    // ****************************************************************
    localparam int ARRAY_COLS = 2048;
    localparam int ARRAY_LINES = 2048;
    localparam int ADDR_W = 12;
    localparam int START_W = 10;
    localparam int OFFSET_W = 7;
    localparam int CODE_W = 10;

    // ****************************************************************
    // Serial upload word: average bit, offset, line start, column start
    // ****************************************************************
    localparam int UPLOAD_W = 28;
    localparam int UPL_X_LSB = 0;
    localparam int UPL_Y_LSB = 10;
    localparam int UPL_OFS_LSB = 20;
    localparam int UPL_AVG_BIT = 27;
    localparam logic [START_W-1:0] START_RST = 10'h000;
    localparam logic [OFFSET_W-1:0] OFFSET_RST = 7'h40;

    // ****************************************************************
    // Timing figures and derived cycle counts
    // ****************************************************************
    localparam int CORE_PERIOD_NS = 8;
    localparam logic [7:0] CORE_CLK_MHZ = 8'h7D;
    localparam logic [7:0] SINGLE_RATE_MHZ = 8'h42;
    localparam logic [7:0] DUAL_RATE_MHZ = 8'h21;
    localparam int FRAME_OVERHEAD_NS = 5000;
    localparam int ROW_OVERHEAD_NS = 200;
    // Least times, so the counts round up to whole cycles.
    localparam int FOT_CYCLES =
        (FRAME_OVERHEAD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int ROT_CYCLES =
        (ROW_OVERHEAD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int CONV_LATENCY = 2;

    // Code a converter produces for one pixel of the model scene.
    function automatic logic [CODE_W-1:0] pix_code(
        input logic [ADDR_W-1:0] line, input logic [ADDR_W-1:0] col);
        return line[CODE_W-1:0] ^ col[CODE_W-1:0];
    endfunction : pix_code

    // One sample, optionally the voltage average of two columns.
    function automatic logic [CODE_W-1:0] sample_code(
        input logic [ADDR_W-1:0] line, input logic [ADDR_W-1:0] col,
        input logic avg);
        logic [CODE_W:0] sum;
        sum = {1'b0, pix_code(line, col)}
            + {1'b0, pix_code(line, ADDR_W'(col + 12'h001))};
        return avg ? sum[CODE_W:1] : pix_code(line, col);
    endfunction : sample_code

endpackage : sensor_readout_pkg

// [rtl/sensor_link_if.sv]
// Link between the sensor readout end and its timing controller.
// Assumes both ends share core_clk; every signal is a registered level.
`timescale 1ns/1ns
`default_nettype none
interface sensor_link_if;
    import sensor_readout_pkg::*;
    logic upl_data;
    logic upl_strobe;
    logic upl_load;
    logic sync_x;
    logic sync_y;
    logic pix_step;
    logic read_en;
    logic dual_mode;
    logic avg_req;
    logic [CODE_W-1:0] out_a;
    logic [CODE_W-1:0] out_b;
    logic out_bus;
    logic out_valid;
    logic [OFFSET_W-1:0] ref_offset;

    modport device (
        input upl_data, upl_strobe, upl_load, sync_x, sync_y,
        input pix_step, read_en, dual_mode, avg_req,
        output out_a, out_b, out_bus, out_valid, ref_offset
    );
    modport controller (
        output upl_data, upl_strobe, upl_load, sync_x, sync_y,
        output pix_step, read_en, dual_mode, avg_req,
        input out_a, out_b, out_bus, out_valid, ref_offset
    );
endinterface : sensor_link_if
`default_nettype wire

// [rtl/pixel_array_window_readout.sv]
// Sensor end: serial settings, window scan registers, column sampling,
// the two converters with their pipeline and the output channels.
// Assumes the controller on the same clock drives every link input.
`timescale 1ns/1ns
`default_nettype none
module pixel_array_window_readout
    import sensor_readout_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    sensor_link_if.device link,
    output logic [ADDR_W-1:0] cur_line,
    output logic [ADDR_W-1:0] cur_col,
    output logic frame_active
);

    // ****************************************************************
    // Settings store
    // ****************************************************************
    logic [UPLOAD_W-1:0] upl_shift;
    logic [UPLOAD_W-1:0] next_upl_shift;
    logic [START_W-1:0] x_start;
    logic [START_W-1:0] next_x_start;
    logic [START_W-1:0] y_start;
    logic [START_W-1:0] next_y_start;
    logic [OFFSET_W-1:0] offset_word;
    logic [OFFSET_W-1:0] next_offset_word;
    logic avg_bit;
    logic next_avg_bit;

    // Shift in MSB first; fields only change on the load pulse, so a
    // half-shifted word never disturbs a readout in progress.
    always_comb begin
        next_upl_shift = upl_shift;
        next_x_start = x_start;
        next_y_start = y_start;
        next_offset_word = offset_word;
        next_avg_bit = avg_bit;
        if (link.upl_strobe) begin
            next_upl_shift = {upl_shift[UPLOAD_W-2:0], link.upl_data};
        end
        if (link.upl_load) begin
            next_x_start = upl_shift[UPL_X_LSB +: START_W];
            next_y_start = upl_shift[UPL_Y_LSB +: START_W];
            next_offset_word = upl_shift[UPL_OFS_LSB +: OFFSET_W];
            next_avg_bit = upl_shift[UPL_AVG_BIT];
        end
    end

    // Settings are never cleared by a frame, only by reset.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            upl_shift <= '0;
            x_start <= START_RST;
            y_start <= START_RST;
            offset_word <= OFFSET_RST;
            avg_bit <= 1'b0;
        end else begin
            upl_shift <= next_upl_shift;
            x_start <= next_x_start;
            y_start <= next_y_start;
            offset_word <= next_offset_word;
            avg_bit <= next_avg_bit;
        end
    end

    // ****************************************************************
    // Scan registers
    // ****************************************************************
    // One column register and two line registers; the second line
    // register tracks the line whose storage nodes are being reset,
    // modelled here as the line just behind the read line.
    logic [ADDR_W-1:0] line_reg;
    logic [ADDR_W-1:0] next_line_reg;
    logic [ADDR_W-1:0] line_prev;
    logic [ADDR_W-1:0] next_line_prev;
    logic [ADDR_W-1:0] col_reg;
    logic [ADDR_W-1:0] next_col_reg;
    logic first_line;
    logic next_first_line;
    logic active;
    logic next_active;
    logic avg_on;
    logic take;
    logic [2:0] col_adv;

    // Averaging needs the pin and the uploaded bit together.
    assign avg_on = link.avg_req & avg_bit;

    // Columns consumed per converter clock for each mode.
    always_comb begin
        case ({link.dual_mode, avg_on})
            2'b00: col_adv = 3'h1;
            2'b01: col_adv = 3'h2;
            2'b10: col_adv = 3'h2;
            2'b11: col_adv = 3'h4;
            default: col_adv = 3'h1;
        endcase
    end

    // A sample is taken only inside the array; past the last column the
    // step still clocks the converters but carries no pixel.
    assign take = link.pix_step & link.read_en & active
        & (col_reg < ADDR_W'(ARRAY_COLS))
        & (line_reg < ADDR_W'(ARRAY_LINES));

    always_comb begin
        next_line_reg = line_reg;
        next_line_prev = line_prev;
        next_col_reg = col_reg;
        next_first_line = first_line;
        next_active = active;
        if (link.sync_y) begin
            // Start value counts pairs of lines.
            next_line_reg = {1'b0, y_start, 1'b0};
            next_line_prev = {1'b0, y_start, 1'b0};
            next_first_line = 1'b1;
            next_active = 1'b1;
        end else if (link.sync_x) begin
            next_col_reg = {1'b0, x_start, 1'b0};
            next_first_line = 1'b0;
            if (!first_line) begin
                // Progressive order: the next line follows directly.
                next_line_prev = line_reg;
                next_line_reg = ADDR_W'(line_reg + 12'h001);
            end
            if (line_reg >= ADDR_W'(ARRAY_LINES - 1) && !first_line) begin
                next_active = 1'b0;
            end
        end else if (take) begin
            next_col_reg = ADDR_W'(col_reg + {9'h000, col_adv});
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            line_reg <= '0;
            line_prev <= '0;
            col_reg <= '0;
            first_line <= 1'b0;
            active <= 1'b0;
        end else begin
            line_reg <= next_line_reg;
            line_prev <= next_line_prev;
            col_reg <= next_col_reg;
            first_line <= next_first_line;
            active <= next_active;
        end
    end

    // ****************************************************************
    // Converters and output channels
    // ****************************************************************
    // Two stages advance on the converter clock, so a code taken on one
    // step leaves on the second step after it. Without further steps the
    // last samples stay inside; the controller must flush them.
    logic [CODE_W-1:0] s1_a;
    logic [CODE_W-1:0] s1_b;
    logic s1_bus;
    logic s1_v;
    logic [CODE_W-1:0] s2_a;
    logic [CODE_W-1:0] s2_b;
    logic s2_bus;
    logic s2_v;
    logic [CODE_W-1:0] next_s1_a;
    logic [CODE_W-1:0] next_s1_b;
    logic next_s1_bus;
    logic next_s1_v;
    logic [CODE_W-1:0] next_out_a;
    logic [CODE_W-1:0] next_out_b;
    logic next_out_bus;
    logic next_out_valid;

    always_comb begin
        next_s1_a = s1_a;
        next_s1_b = s1_b;
        next_s1_bus = s1_bus;
        next_s1_v = s1_v;
        next_out_a = link.out_a;
        next_out_b = link.out_b;
        next_out_bus = link.out_bus;
        next_out_valid = 1'b0;
        if (link.pix_step) begin
            next_s1_v = take;
            if (take) begin
                // Even converter on channel A, odd converter on B.
                next_s1_a = sample_code(line_reg, col_reg, avg_on);
                next_s1_b = sample_code(line_reg,
                    ADDR_W'(col_reg + (avg_on ? 12'h002 : 12'h001)),
                    avg_on);
                // Single channel: bus follows the column parity, or column bit 1 when averaging.
                next_s1_bus = avg_on ? col_reg[1] : col_reg[0];
            end
            next_out_a = s2_a;
            next_out_b = link.dual_mode ? s2_b : '0;
            next_out_bus = link.dual_mode ? 1'b0 : s2_bus;
            next_out_valid = s2_v;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s1_a <= '0;
            s1_b <= '0;
            s1_bus <= 1'b0;
            s1_v <= 1'b0;
            s2_a <= '0;
            s2_b <= '0;
            s2_bus <= 1'b0;
            s2_v <= 1'b0;
            link.out_a <= '0;
            link.out_b <= '0;
            link.out_bus <= 1'b0;
            link.out_valid <= 1'b0;
        end else begin
            s1_a <= next_s1_a;
            s1_b <= next_s1_b;
            s1_bus <= next_s1_bus;
            s1_v <= next_s1_v;
            if (link.pix_step) begin
                s2_a <= s1_a;
                s2_b <= s1_b;
                s2_bus <= s1_bus;
                s2_v <= s1_v;
            end
            link.out_a <= next_out_a;
            link.out_b <= next_out_b;
            link.out_bus <= next_out_bus;
            link.out_valid <= next_out_valid;
        end
    end

    // ****************************************************************
    // Reference level and user-side status
    // ****************************************************************
    // The reference is steady; it moves only when a new word is loaded.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            link.ref_offset <= OFFSET_RST;
            cur_line <= '0;
            cur_col <= '0;
            frame_active <= 1'b0;
        end else begin
            link.ref_offset <= offset_word;
            cur_line <= line_reg;
            cur_col <= col_reg;
            frame_active <= active;
        end
    end

endmodule : pixel_array_window_readout
`default_nettype wire

// [rtl/readout_timing_controller.sv]
// Controller end: uploads the settings, paces frame and row overheads,
// generates the converter clock enable and captures the pixel codes.
// Assumes the sensor end shares core_clk and nrst.
`timescale 1ns/1ns
`default_nettype none
module readout_timing_controller
    import sensor_readout_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    sensor_link_if.controller link,
    input wire logic start,
    input wire logic [START_W-1:0] x_start,
    input wire logic [START_W-1:0] y_start,
    input wire logic [ADDR_W-1:0] win_cols,
    input wire logic [ADDR_W-1:0] win_lines,
    input wire logic [OFFSET_W-1:0] offset,
    input wire logic avg_mode,
    input wire logic dual,
    output logic busy,
    output logic frame_done,
    output logic [CODE_W-1:0] px_a,
    output logic [CODE_W-1:0] px_b,
    output logic px_bus,
    output logic px_valid
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_UPLOAD = 3'b001,
        ST_LOAD = 3'b010,
        ST_FOT = 3'b011,
        ST_ROT = 3'b100,
        ST_PIX = 3'b101,
        ST_FLUSH = 3'b110
    } ctl_state_t;

    ctl_state_t state, next_state;
    logic [UPLOAD_W-1:0] word, next_word;
    logic [ADDR_W-1:0] cnt, next_cnt;
    logic [ADDR_W-1:0] steps, next_steps;
    logic [ADDR_W-1:0] lines_left, next_lines_left;
    logic [7:0] acc, next_acc;
    logic [7:0] acc_sum;
    logic next_upl_data, next_upl_strobe, next_upl_load;
    logic next_sync_x, next_sync_y, next_pix_step, next_read_en;
    logic next_dual, next_avg, next_busy, next_done;

    // Fractional divider: average step rate is rate/125 of core_clk.
    assign acc_sum = acc + (link.dual_mode ? DUAL_RATE_MHZ
                                           : SINGLE_RATE_MHZ);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_word = word;
        next_cnt = cnt;
        next_steps = steps;
        next_lines_left = lines_left;
        next_acc = acc;
        next_upl_data = link.upl_data;
        next_upl_strobe = 1'b0;
        next_upl_load = 1'b0;
        next_sync_x = 1'b0;
        next_sync_y = 1'b0;
        next_pix_step = 1'b0;
        next_read_en = 1'b0;
        next_dual = link.dual_mode;
        next_avg = link.avg_req;
        next_busy = busy;
        next_done = 1'b0;
        case (state)
            ST_IDLE: if (start) begin
                next_word = {avg_mode, offset, y_start, x_start};
                next_dual = dual;
                next_avg = avg_mode;
                next_lines_left = win_lines;
                next_steps = win_cols >> ({1'b0, dual} + {1'b0, avg_mode});
                next_cnt = '0;
                next_busy = 1'b1;
                next_state = ST_UPLOAD;
            end
            ST_UPLOAD: begin
                next_upl_data = word[UPLOAD_W-1];
                next_upl_strobe = 1'b1;
                next_word = {word[UPLOAD_W-2:0], 1'b0};
                next_cnt = ADDR_W'(cnt + 12'h001);
                if (cnt == ADDR_W'(UPLOAD_W - 1)) next_state = ST_LOAD;
            end
            ST_LOAD: begin
                next_upl_load = 1'b1;
                next_cnt = '0;
                next_state = ST_FOT;
            end
            ST_FOT: begin
                next_sync_y = (cnt == '0);
                next_cnt = ADDR_W'(cnt + 12'h001);
                if (cnt == ADDR_W'(FOT_CYCLES - 1)) begin
                    next_cnt = '0;
                    next_state = ST_ROT;
                end
            end
            ST_ROT: begin
                next_sync_x = (cnt == '0);
                next_cnt = ADDR_W'(cnt + 12'h001);
                if (cnt == ADDR_W'(ROT_CYCLES - 1)) begin
                    next_cnt = steps;
                    next_acc = '0;
                    next_state = ST_PIX;
                end
            end
            ST_PIX, ST_FLUSH: begin
                next_acc = acc_sum;
                if (acc_sum >= CORE_CLK_MHZ) begin
                    next_acc = acc_sum - CORE_CLK_MHZ;
                    next_pix_step = 1'b1;
                    next_read_en = (state == ST_PIX);
                    next_cnt = ADDR_W'(cnt - 12'h001);
                    if (cnt <= 12'h001 && state == ST_PIX) begin
                        next_cnt = ADDR_W'(CONV_LATENCY);
                        next_state = ST_FLUSH;
                    end else if (cnt <= 12'h001) begin
                        next_cnt = '0;
                        next_lines_left = ADDR_W'(lines_left - 12'h001);
                        next_state = ST_ROT;
                        if (lines_left <= 12'h001) begin
                            next_busy = 1'b0;
                            next_done = 1'b1;
                            next_state = ST_IDLE;
                        end
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            word <= '0;
            cnt <= '0;
            steps <= '0;
            lines_left <= '0;
            acc <= '0;
            link.upl_data <= 1'b0;
            link.upl_strobe <= 1'b0;
            link.upl_load <= 1'b0;
            link.sync_x <= 1'b0;
            link.sync_y <= 1'b0;
            link.pix_step <= 1'b0;
            link.read_en <= 1'b0;
            link.dual_mode <= 1'b0;
            link.avg_req <= 1'b0;
            busy <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            state <= next_state;
            word <= next_word;
            cnt <= next_cnt;
            steps <= next_steps;
            lines_left <= next_lines_left;
            acc <= next_acc;
            link.upl_data <= next_upl_data;
            link.upl_strobe <= next_upl_strobe;
            link.upl_load <= next_upl_load;
            link.sync_x <= next_sync_x;
            link.sync_y <= next_sync_y;
            link.pix_step <= next_pix_step;
            link.read_en <= next_read_en;
            link.dual_mode <= next_dual;
            link.avg_req <= next_avg;
            busy <= next_busy;
            frame_done <= next_done;
        end
    end

    // ****************************************************************
    // Pixel capture
    // ****************************************************************
    // Codes are re-registered so user outputs come from flip-flops.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            px_a <= '0;
            px_b <= '0;
            px_bus <= 1'b0;
            px_valid <= 1'b0;
        end else begin
            px_valid <= link.out_valid;
            if (link.out_valid) begin
                px_a <= link.out_a;
                px_b <= link.out_b;
                px_bus <= link.out_bus;
            end
        end
    end

endmodule : readout_timing_controller
`default_nettype wire

// [test/sensor_link_assertions.sv]
// Link checker: timing properties on the signals between the two ends.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module sensor_link_assertions
    import sensor_readout_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic upl_strobe,
    input wire logic upl_load,
    input wire logic sync_x,
    input wire logic sync_y,
    input wire logic pix_step,
    input wire logic dual_mode,
    input wire logic out_bus,
    input wire logic out_valid,
    input wire logic [OFFSET_W-1:0] ref_offset
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic [10:0] gap, next_gap;
    // Cycles since the frame sync; it saturates so it never wraps short.
    always_comb begin
        next_gap = sync_y ? 11'h000 : gap + {10'h000, ~&gap};
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) gap <= 11'h000;
        else gap <= next_gap;
    end
    property p_load; upl_load |-> $past(upl_strobe) && !upl_strobe;
    endproperty
    a_load: assert property (p_load) else $error("bad load");
    property p_sync; upl_load |=> sync_y;
    endproperty
    a_sync: assert property (p_sync) else $error("no sync");
    property p_frame; sync_x |-> gap >= FOT_CYCLES - 1;
    endproperty
    a_frame: assert property (p_frame) else $error("short");
    property p_row; sync_x |=> !pix_step [*8];
    endproperty
    a_row: assert property (p_row) else $error("early step");
    property p_pipe; out_valid |-> $past(pix_step);
    endproperty
    a_pipe: assert property (p_pipe) else $error("stray out");
    property p_ref;
        !$past(upl_load) && !$past(upl_load, 2) |-> $stable(ref_offset);
    endproperty
    a_ref: assert property (p_ref) else $error("ref moved");
    property p_dual; out_valid && dual_mode |-> !out_bus;
    endproperty
    a_dual: assert property (p_dual) else $error("bus set");
    // Dual channels step at 33/125 of the clock, so two idle cycles
    // always follow a step; single mode at 66/125 may step twice.
    property p_rate; pix_step && dual_mode |=> !pix_step [*2];
    endproperty
    a_rate: assert property (p_rate) else $error("too fast");
    property p_burst; pix_step ##1 pix_step |=> !pix_step;
    endproperty
    a_burst: assert property (p_burst) else $error("burst");
endmodule : sensor_link_assertions
`default_nettype wire

// [test/test_pixel_array_window_readout.sv]
// Bench for the readout pair: one 8 x 3 window in each channel mode.
// Assumes the package, the link and both ends are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_pixel_array_window_readout;
    import sensor_readout_pkg::*;
    logic core_clk = 1'b0, nrst = 1'b0, start = 1'b0;
    logic avg_mode = 1'b0, dual = 1'b0;
    logic [START_W-1:0] x_start = '0, y_start = '0;
    logic [OFFSET_W-1:0] offset = '0;
    logic frame_done, px_bus, px_valid, busy, frame_active;
    logic [ADDR_W-1:0] cur_line, cur_col;
    logic [CODE_W-1:0] px_a, px_b;
    logic [20:0] want;
    logic [20:0] expq[$];
    int n_errors = 0, compares = 0, cycles = 0;
    sensor_link_if link ();
    // Window size is fixed; start, offset and mode vary per frame.
    pixel_array_window_readout i_pixel_array_window_readout (
        .core_clk(core_clk), .nrst(nrst), .link(link),
        .cur_line(cur_line), .cur_col(cur_col),
        .frame_active(frame_active));
    readout_timing_controller i_readout_timing_controller (
        .core_clk(core_clk), .nrst(nrst), .link(link), .start(start),
        .x_start(x_start), .y_start(y_start), .win_cols(12'h008),
        .win_lines(12'h003), .offset(offset), .avg_mode(avg_mode),
        .dual(dual), .busy(busy), .frame_done(frame_done), .px_a(px_a),
        .px_b(px_b), .px_bus(px_bus), .px_valid(px_valid));
    sensor_link_assertions i_sensor_link_assertions (
        .core_clk(core_clk), .nrst(nrst), .upl_strobe(link.upl_strobe),
        .upl_load(link.upl_load), .sync_x(link.sync_x),
        .sync_y(link.sync_y), .pix_step(link.pix_step),
        .dual_mode(link.dual_mode), .out_bus(link.out_bus),
        .out_valid(link.out_valid), .ref_offset(link.ref_offset));
    // Core clock, 8 ns period.
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    // Hang guard, several times the expected run length.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic chk(input logic [20:0] g, x);
        compares++;
        if (g !== x) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    task automatic summarize();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    // Scene code, or the floor of the mean of two neighbouring columns.
    function automatic logic [9:0] smp(input int l, c, input logic v);
        logic [10:0] t;
        t = 11'(10'(l ^ c)) + 11'(10'(l ^ (c + 1)));
        return v ? t[10:1] : 10'(l ^ c);
    endfunction : smp
    // Each captured pixel retires the oldest expectation.
    always @(negedge core_clk) begin
        if (px_valid === 1'b1) begin
            want = expq.size() > 0 ? expq.pop_front() : 'x;
            chk({px_a, px_b, px_bus}, want);
        end
    end
    // Notes the window's codes in scan order, then runs one frame.
    task automatic frame(input logic [1:0] m, input logic [9:0] xs, ys,
        input logic [6:0] of);
        int l, c, w;
        w = (1 + m[0]) * (1 + m[1]);
        for (l = 2 * ys; l < 2 * ys + 3; l++) begin
            for (c = 2 * xs; c < 2 * xs + 8; c += w) begin
                expq.push_back({smp(l, c, m[1]),
                    m[0] ? smp(l, c + 1 + m[1], m[1]) : 10'h000,
                    ~m[0] & (m[1] ? c[1] : c[0])});
            end
        end
        @(posedge core_clk);
        #1;
        {avg_mode, dual, x_start, y_start, offset, start} =
            {m, xs, ys, of, 1'b1};
        @(posedge core_clk);
        #1;
        start = 1'b0;
        chk(21'(busy), 21'h1);
        for (w = 0; w < 9000 && frame_done !== 1'b1; w++)
            @(negedge core_clk);
        repeat (4) @(negedge core_clk);
        chk(21'(expq.size()), 21'h0);
        chk(21'(link.ref_offset), 21'(of));
        // Three lines from the even start, eight columns scanned.
        chk(21'(cur_line), 21'(2 * ys + 2));
        chk(21'(cur_col), 21'(2 * xs + 8));
        chk(21'(frame_active), 21'h1);
        chk(21'(busy), 21'h0);
    endtask : frame
    // Every mode once with random starts, then the smallest odd start.
    initial begin
        int m;
        void'($urandom(32'hc68c9a42));
        repeat (4) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        chk(21'(link.ref_offset), 21'(OFFSET_RST));
        for (m = 0; m < 4; m++) begin
            frame(2'(m), 10'($urandom % 900), 10'($urandom % 900),
                7'($urandom));
        end
        frame(2'b00, 10'h001, 10'h001, 7'h00);
        summarize();
    end
endmodule : test_pixel_array_window_readout
`default_nettype wire
